// ==== uib_defs.svh ====
// constants for the uart interrupt identification and baud generator
// assumes one 125 MHz clock and a plain byte-wide register port
`ifndef UIB_DEFS_SVH
`define UIB_DEFS_SVH
`define UIB_A_BUF     4'h0
`define UIB_A_IER     4'h1
`define UIB_A_IDF     4'h2
`define UIB_A_CFG     4'h3
`define UIB_A_HCR     4'h4
`define UIB_A_LSR     4'h5
`define UIB_A_HSR     4'h6
`define UIB_A_SCR     4'h7
`define UIB_A_DLL     4'h8
`define UIB_A_DLH     4'h9
`define UIB_ID_NONE   4'h1
`define UIB_ID_LS     4'h6
`define UIB_ID_DR     4'h4
`define UIB_ID_TO     4'hc
`define UIB_ID_TE     4'h2
`define UIB_ID_HS     4'h0
`define UIB_MCLK_MHZ  8'h7d
`define UIB_SRC_MHZ   8'h18
`define UIB_PD_DEN    8'h0d
`define UIB_PD13_NUM  8'h01
`define UIB_PD1625_NUM 8'h08
`define UIB_CHAR_BITS 10
`define UIB_OVERSMP   16
`define UIB_TOUT_CHARS 4
`define UIB_TRIG1     5'h01
`define UIB_TRIG4     5'h04
`define UIB_TRIG8     5'h08
`define UIB_TRIG14    5'h0e
`define UIB_DIV_RST   16'h0001
`define UIB_HCR_OE    3
`endif

// ==== uib_pkg.sv ====
// types shared by the uart interrupt and baud logic
// assumes the serial core delivers its events on the same clock
package uib_pkg;
  typedef struct packed {
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic silent_line;
    logic cts_chg;
    logic dsr_chg;
    logic ring_rise;
    logic dcd_chg;
    logic tx_empty_set;
    logic rx_push;
  } uib_src_s;
  typedef enum logic [1:0] {
    UIB_PD13   = 2'h0,
    UIB_PD1625 = 2'h1,
    UIB_PD1    = 2'h2
  } uib_pdiv_e;
endpackage : uib_pkg

// ==== uib_top.sv ====
// interrupt identification, enables, scratch and 16x baud enable
// assumes the serial core runs on MCLK and pulses its events in SRC
`timescale 1ns/1ps
`default_nettype none
`include "uib_defs.svh"
module uib_top #(
  parameter int TOUT_TICKS = `UIB_TOUT_CHARS * `UIB_CHAR_BITS * `UIB_OVERSMP
) (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             RESETN,
  // register port
  input  wire logic [3:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [7:0]       RDATA,
  // serial core status
  input  wire uib_pkg::uib_src_s SRC,
  input  wire logic [4:0]       RX_COUNT,
  input  wire logic [7:0]       LSR_IN,
  input  wire logic [3:0]       MSR_IN,
  // serial core control
  output logic      [7:0]       TX_DATA,
  output logic                  TX_WRITE,
  output logic                  RX_READ,
  output logic                  FIFO_MODE,
  output logic                  RX_FIFO_CLR,
  output logic                  TX_FIFO_CLR,
  output logic      [4:0]       HS_CTRL,
  output logic                  BAUD16_EN,
  output logic                  IRQ
);

  logic [7:0]  ier_reg;
  logic [7:0]  hcr_reg;
  logic [7:0]  scr_reg;
  logic [7:0]  dll_reg;
  logic [7:0]  dlh_reg;
  logic        fifo_en_reg;
  logic [1:0]  trig_sel_reg;
  logic [1:0]  pdiv_reg;
  logic        hspeed_reg;
  logic        ls_pend_reg;
  logic        hs_pend_reg;
  logic [3:0]  hs_flag_reg;
  logic [3:0]  ls_flag_reg;
  logic        te_reg;
  logic        tout_reg;
  logic [9:0]  tout_cnt_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  txd_reg;
  logic        irq_reg;
  logic [7:0]  src_acc_reg;
  logic [7:0]  pd_acc_reg;
  logic [15:0] div_cnt_reg;
  logic        b16_reg;
  localparam logic [15:0] div_rst = `UIB_DIV_RST;

  // register decode
  wire wr_ier = WR && (ADDR == `UIB_A_IER);
  wire wr_fcr = WR && (ADDR == `UIB_A_IDF);
  wire wr_cfg = WR && (ADDR == `UIB_A_CFG);
  wire wr_hcr = WR && (ADDR == `UIB_A_HCR);
  wire wr_scr = WR && (ADDR == `UIB_A_SCR);
  wire wr_dll = WR && (ADDR == `UIB_A_DLL);
  wire wr_dlh = WR && (ADDR == `UIB_A_DLH);
  wire wr_buf = WR && (ADDR == `UIB_A_BUF);
  wire rd_buf = RD && (ADDR == `UIB_A_BUF);
  wire rd_idr = RD && (ADDR == `UIB_A_IDF);
  wire rd_lsr = RD && (ADDR == `UIB_A_LSR);
  wire rd_hsr = RD && (ADDR == `UIB_A_HSR);

  // event inputs
  wire [3:0] ls_evt = {SRC.silent_line, SRC.framing_err,
                       SRC.parity_err, SRC.overrun};
  wire [3:0] hs_evt = {SRC.dcd_chg, SRC.ring_rise,
                       SRC.dsr_chg, SRC.cts_chg};

  // trigger level lookup
  wire [4:0] trig_lvl = (trig_sel_reg == 2'h0) ? `UIB_TRIG1 :
                        (trig_sel_reg == 2'h1) ? `UIB_TRIG4 :
                        (trig_sel_reg == 2'h2) ? `UIB_TRIG8 :
                                                 `UIB_TRIG14;

  // data ready level
  wire data_rdy = fifo_en_reg ? (RX_COUNT >= trig_lvl)
                              : (RX_COUNT != 5'h00);

  // per-class enable gating
  wire ls_on = ls_pend_reg & ier_reg[2];
  wire to_on = tout_reg & fifo_en_reg & ier_reg[0];
  wire dr_on = data_rdy & ier_reg[0];
  wire te_on = te_reg & ier_reg[1];
  wire hs_on = hs_pend_reg & ier_reg[3];
  wire any_on = ls_on | to_on | dr_on | te_on | hs_on;

  // priority encode of the pending class
  wire [3:0] id_code = ls_on ? `UIB_ID_LS :
                       to_on ? `UIB_ID_TO :
                       dr_on ? `UIB_ID_DR :
                       te_on ? `UIB_ID_TE :
                       hs_on ? `UIB_ID_HS :
                               `UIB_ID_NONE;
  wire [7:0] ident = {fifo_en_reg, fifo_en_reg, 2'b00,
                      id_code};

  // tx empty clears when a read reports it
  wire te_rd_clr = rd_idr && (id_code == `UIB_ID_TE);

  // read mux
  wire [7:0] rd_mux =
    (ADDR == `UIB_A_BUF) ? 8'h00 :
    (ADDR == `UIB_A_IER) ? {4'h0, ier_reg[3:0]} :
    (ADDR == `UIB_A_IDF) ? ident :
    (ADDR == `UIB_A_CFG) ? {5'h00, hspeed_reg, pdiv_reg} :
    (ADDR == `UIB_A_HCR) ? {3'h0, hcr_reg[4:0]} :
    (ADDR == `UIB_A_LSR) ? {LSR_IN[7:5], ls_flag_reg,
                            LSR_IN[0]} :
    (ADDR == `UIB_A_HSR) ? {MSR_IN, hs_flag_reg} :
    (ADDR == `UIB_A_SCR) ? scr_reg :
    (ADDR == `UIB_A_DLL) ? dll_reg :
    (ADDR == `UIB_A_DLH) ? dlh_reg : 8'h00;

  // control registers
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ier_reg      <= 8'h00;
      hcr_reg      <= 8'h00;
      scr_reg      <= 8'h00;
      dll_reg      <= div_rst[7:0];
      dlh_reg      <= div_rst[15:8];
      fifo_en_reg  <= 1'b0;
      trig_sel_reg <= 2'h0;
      pdiv_reg     <= uib_pkg::UIB_PD13;
      hspeed_reg   <= 1'b0;
    end else begin
      if (wr_ier) ier_reg <= {4'h0, WDATA[3:0]};
      if (wr_hcr) hcr_reg <= WDATA;
      if (wr_scr) scr_reg <= WDATA;
      if (wr_dll) dll_reg <= WDATA;
      if (wr_dlh) dlh_reg <= WDATA;
      if (wr_cfg) pdiv_reg <= WDATA[1:0];
      if (wr_cfg) hspeed_reg <= WDATA[2];
      if (wr_fcr) fifo_en_reg <= WDATA[0];
      if (wr_fcr && WDATA[0]) trig_sel_reg <= WDATA[7:6];
    end
  end

  // sticky interrupt sources, a set wins over a clear
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ls_flag_reg <= 4'h0;
      hs_flag_reg <= 4'h0;
      ls_pend_reg <= 1'b0;
      hs_pend_reg <= 1'b0;
      te_reg      <= 1'b1;
    end else begin
      ls_flag_reg <= ls_evt | (rd_lsr ? 4'h0 : ls_flag_reg);
      hs_flag_reg <= hs_evt | (rd_hsr ? 4'h0 : hs_flag_reg);
      ls_pend_reg <= (|ls_evt) | (ls_pend_reg & ~rd_lsr);
      hs_pend_reg <= (|hs_evt) | (hs_pend_reg & ~rd_hsr);
      te_reg <= SRC.tx_empty_set |
                (te_reg & ~wr_buf & ~te_rd_clr);
    end
  end

  // receive timeout: idle data for four character times
  wire tout_rst = SRC.rx_push | rd_buf | (RX_COUNT == 5'h00) |
                  !fifo_en_reg;
  wire tout_hit = (tout_cnt_reg == 10'(TOUT_TICKS - 1)) && b16_reg;

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tout_cnt_reg <= 10'h000;
      tout_reg     <= 1'b0;
    end else begin
      if (tout_rst)
        tout_cnt_reg <= 10'h000;
      else if (b16_reg && !tout_hit && !tout_reg)
        tout_cnt_reg <= tout_cnt_reg + 10'h001;
      tout_reg <= (tout_hit & ~tout_rst) |
                  (tout_reg & ~rd_buf & fifo_en_reg);
    end
  end

  // 24 MHz enable from MCLK: add 24, wrap at 125
  wire [8:0] src_sum = {1'b0, src_acc_reg} + {1'b0, `UIB_SRC_MHZ};
  wire       src_en  = src_sum >= {1'b0, `UIB_MCLK_MHZ};

  // pre-divider as num/den accumulator on the 24 MHz enable
  wire [7:0] pd_num = hspeed_reg ? `UIB_PD_DEN :
                      (pdiv_reg == uib_pkg::UIB_PD13)   ? `UIB_PD13_NUM :
                      (pdiv_reg == uib_pkg::UIB_PD1625) ? `UIB_PD1625_NUM :
                                                          `UIB_PD_DEN;
  wire [8:0] pd_sum = {1'b0, pd_acc_reg} + {1'b0, pd_num};
  wire       pd_hit = pd_sum >= {1'b0, `UIB_PD_DEN};
  wire       ref_en = src_en && pd_hit;

  // divisor counter on the pre-divided rate
  wire [15:0] divisor = {dlh_reg, dll_reg};
  wire        div_tc  = div_cnt_reg <= 16'h0001;

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      src_acc_reg <= 8'h00;
      pd_acc_reg  <= 8'h00;
      div_cnt_reg <= `UIB_DIV_RST;
      b16_reg     <= 1'b0;
    end else begin
      src_acc_reg <= src_en ? 8'(src_sum - {1'b0, `UIB_MCLK_MHZ})
                            : src_sum[7:0];
      if (src_en)
        pd_acc_reg <= pd_hit ? 8'(pd_sum - {1'b0, `UIB_PD_DEN})
                             : pd_sum[7:0];
      if (ref_en)
        div_cnt_reg <= div_tc ? divisor
                              : div_cnt_reg - 16'h0001;
      b16_reg <= ref_en && div_tc;
    end
  end

  // read data, command pulses and outputs
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rdata_reg <= 8'h00;
      txd_reg   <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      rdata_reg <= RD ? rd_mux : 8'h00;
      if (wr_buf) txd_reg <= WDATA;
      irq_reg <= any_on && hcr_reg[`UIB_HCR_OE];
    end
  end

  // fifo clears act only with the enable bit in the same write
  assign RX_FIFO_CLR = wr_fcr && WDATA[0] && WDATA[1];
  assign TX_FIFO_CLR = wr_fcr && WDATA[0] && WDATA[2];
  assign TX_WRITE    = wr_buf;
  assign RX_READ     = rd_buf;
  assign RDATA       = rdata_reg;
  assign TX_DATA     = txd_reg;
  assign FIFO_MODE   = fifo_en_reg;
  assign HS_CTRL     = hcr_reg[4:0];
  assign BAUD16_EN   = b16_reg;
  assign IRQ         = irq_reg;

  // checks
  property p_id_hi;
    @(posedge MCLK) disable iff (!RESETN)
    rd_idr |=> RDATA[7:6] == {2{$past(fifo_en_reg)}};
  endproperty
  a_id_hi: assert property (p_id_hi) else $error("ident mode bits");

  property p_id_zero;
    @(posedge MCLK) disable iff (!RESETN)
    rd_idr |=> RDATA[5:4] == 2'b00;
  endproperty
  a_id_zero: assert property (p_id_zero) else $error("ident 5:4");

  property p_id_b3;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_idr && !fifo_en_reg) |=> !RDATA[3];
  endproperty
  a_id_b3: assert property (p_id_b3) else $error("ident bit3");

  property p_none;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_idr && ier_reg[3:0] == 4'h0) |=> RDATA[3:0] == `UIB_ID_NONE;
  endproperty
  a_none: assert property (p_none) else $error("masked not idle");

  property p_ier_hi;
    @(posedge MCLK) disable iff (!RESETN)
    (RD && ADDR == `UIB_A_IER) |=> RDATA[7:4] == 4'h0;
  endproperty
  a_ier_hi: assert property (p_ier_hi) else $error("ier high");

  property p_irq_oe;
    @(posedge MCLK) disable iff (!RESETN)
    !hcr_reg[`UIB_HCR_OE] |=> !IRQ;
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("irq gated");

  property p_ls_clr;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_lsr && ls_evt == 4'h0) |=> !ls_pend_reg;
  endproperty
  a_ls_clr: assert property (p_ls_clr) else $error("lsr clear");

  property p_te_clr;
    @(posedge MCLK) disable iff (!RESETN)
    (wr_buf && !SRC.tx_empty_set) |=> !te_reg;
  endproperty
  a_te_clr: assert property (p_te_clr) else $error("tx empty clear");

  property p_hs_set;
    @(posedge MCLK) disable iff (!RESETN)
    SRC.cts_chg ##1 (ier_reg[3] && !ls_on && !dr_on && !to_on && !te_on)
      |-> id_code == `UIB_ID_HS;
  endproperty
  a_hs_set: assert property (p_hs_set) else $error("hs class");

  property p_scr;
    @(posedge MCLK) disable iff (!RESETN)
    wr_scr ##1 !WR ##1 (RD && ADDR == `UIB_A_SCR) |=> RDATA == $past(WDATA, 3);
  endproperty
  a_scr: assert property (p_scr) else $error("scratch readback");

  property p_b16;
    @(posedge MCLK) disable iff (!RESETN)
    BAUD16_EN |=> !BAUD16_EN;
  endproperty
  a_b16: assert property (p_b16) else $error("baud pulse width");

  property p_ls_set;
    @(posedge MCLK) disable iff (!RESETN)
    (|ls_evt) |=> ls_pend_reg;
  endproperty
  a_ls_set: assert property (p_ls_set) else $error("lsr set");

  property p_ls_id;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_idr && ls_on) |=> RDATA[3:0] == `UIB_ID_LS;
  endproperty
  a_ls_id: assert property (p_ls_id) else $error("lsr first");

  property p_hs_clr;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_hsr && hs_evt == 4'h0) |=> !hs_pend_reg;
  endproperty
  a_hs_clr: assert property (p_hs_clr) else $error("hsr clear");

  property p_te_id;
    @(posedge MCLK) disable iff (!RESETN)
    (te_rd_clr && !SRC.tx_empty_set) |=> !te_reg;
  endproperty
  a_te_id: assert property (p_te_id) else $error("tx empty ident clear");

  property p_to_id;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_idr && to_on && !ls_on) |=> RDATA[3:2] == 2'b11;
  endproperty
  a_to_id: assert property (p_to_id) else $error("timeout code");

  property p_to_clr;
    @(posedge MCLK) disable iff (!RESETN)
    rd_buf |=> !tout_reg;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("timeout clear");

  property p_pend;
    @(posedge MCLK) disable iff (!RESETN)
    (rd_idr && any_on) |=> !RDATA[0];
  endproperty
  a_pend: assert property (p_pend) else $error("pending bit");

  property p_irq_on;
    @(posedge MCLK) disable iff (!RESETN)
    (any_on && hcr_reg[`UIB_HCR_OE]) |=> IRQ;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  property p_irq_mask;
    @(posedge MCLK) disable iff (!RESETN)
    (ier_reg[3:0] == 4'h0) |=> !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq masked");

  property p_div_rld;
    @(posedge MCLK) disable iff (!RESETN)
    (ref_en && div_tc) |=> div_cnt_reg == $past(divisor);
  endproperty
  a_div_rld: assert property (p_div_rld) else $error("divisor reload");

endmodule : uib_top
`default_nettype wire

// ==== uib_core_model.sv ====
// serial core stand-in: event pulses and a receive byte count
// assumes bench commands arrive one cycle ahead, all on mclk
`timescale 1ns/1ps
`default_nettype none
module uib_core_model (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // bench command and block control
  input  wire uib_pkg::uib_src_s cmd,
  input  wire logic              rx_read,
  input  wire logic              rx_clr,
  // toward the block
  output uib_pkg::uib_src_s      src,
  output logic [4:0]             rx_count
);
  // events leave one cycle late, as a real core's registered flags would
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      src      <= '0;
      rx_count <= 5'h00;
    end else begin
      src <= cmd;
      if (rx_clr)
        rx_count <= 5'h00;
      else
        rx_count <= rx_count + 5'(cmd.rx_push) - 5'(rx_read && rx_count != 5'h00);
    end
  end
endmodule : uib_core_model
`default_nettype wire

// ==== uib_tb.sv ====
// bench for the interrupt identification, enables and baud enable
// assumes package, header and core model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "uib_defs.svh"
module tb;
  localparam int NCYC = 8000;
  logic              mclk = 1'b0;
  logic              resetn = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              rd_p = 1'b0;
  logic [7:0]        rdata;
  uib_pkg::uib_src_s cmd = '0;
  uib_pkg::uib_src_s src;
  logic [4:0]        rx_count;
  logic              rx_read, rx_clr, baud_en, irq;
  logic [7:0]        tx_data;
  logic [4:0]        hs_ctrl;
  logic              tx_wr, tx_clr, fifo_mode;
  int                n_txw = 0;
  int                n_tfc = 0;
  logic [7:0]        exp_q[$];
  int                failures = 0;
  int                total_checks = 0;
  int                d, c;
  logic [7:0]        r;
  logic [9:0]        ev_t [4] = '{10'h001, 10'h002, 10'h100, 10'h010};
  logic [7:0]        code_t [4] = '{8'h04, 8'h02, 8'h06, 8'h00};
  logic [3:0]        ca_t [4] = '{`UIB_A_BUF, `UIB_A_IDF, `UIB_A_LSR, `UIB_A_HSR};
  logic [7:0]        cv_t [4] = '{8'h00, 8'h01, 8'h04, 8'h02};
  logic [7:0]        cfg_t [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  int                num_t [4] = '{1, 8, 13, 13};

  always #4 mclk = ~mclk;

  uib_top #(.TOUT_TICKS(16)) dut (.MCLK(mclk), .RESETN(resetn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SRC(src), .RX_COUNT(rx_count),
    .LSR_IN(8'h00), .MSR_IN(4'h0), .TX_DATA(tx_data), .TX_WRITE(tx_wr),
    .RX_READ(rx_read), .FIFO_MODE(fifo_mode), .RX_FIFO_CLR(rx_clr),
    .TX_FIFO_CLR(tx_clr), .HS_CTRL(hs_ctrl),
    .BAUD16_EN(baud_en), .IRQ(irq));

  uib_core_model core (.mclk(mclk), .resetn(resetn), .cmd(cmd), .rx_read(rx_read),
    .rx_clr(rx_clr), .src(src), .rx_count(rx_count));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pulse counts drift with the fractional 24 MHz enable, so allow two
  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got > exp + 2 || got + 2 < exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // read data stand only in the cycle after the strobe
  always @(posedge mclk) rd_p <= rd;
  always @(posedge mclk) begin
    if (tx_wr === 1'b1) n_txw++;
    if (tx_clr === 1'b1) n_tfc++;
  end
  always @(negedge mclk) begin
    if (rd_p)
      chk(rdata, exp_q.pop_front());
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
  endtask : rd_reg

  task automatic pulse(input logic [9:0] e);
    @(posedge mclk);
    cmd <= uib_pkg::uib_src_s'(e);
    @(posedge mclk);
    cmd <= '0;
    repeat (3) @(posedge mclk);
  endtask : pulse

  task automatic irq_is(input logic b);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({7'h00, irq}, {7'h00, b});
  endtask : irq_is

  initial begin
    #700000;
    failures++;
    end_sim();
  end

  initial begin
    r = 8'($urandom(46181));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd_reg(`UIB_A_IDF, 8'h01);
    rd_reg(`UIB_A_DLL, 8'h01);
    rd_reg(`UIB_A_DLH, 8'h00);
    rd_reg(4'ha, 8'h00);
    wr_reg(`UIB_A_IER, 8'hff);
    rd_reg(`UIB_A_IER, 8'h0f);
    irq_is(1'b0);
    rd_reg(`UIB_A_IDF, 8'h02);
    rd_reg(`UIB_A_IDF, 8'h01);
    r = 8'($urandom);
    wr_reg(`UIB_A_SCR, r);
    rd_reg(`UIB_A_SCR, r);
    wr_reg(`UIB_A_HCR, 8'h08);
    @(negedge mclk);
    chk({3'h0, hs_ctrl}, 8'h08);
    // each class masked, then enabled alone, then cleared
    for (int i = 0; i < 4; i++) begin
      wr_reg(`UIB_A_IER, 8'h0f & ~(8'h01 << i));
      pulse(ev_t[i]);
      rd_reg(`UIB_A_IDF, 8'h01);
      wr_reg(`UIB_A_IER, 8'h01 << i);
      irq_is(1'b1);
      rd_reg(`UIB_A_IDF, code_t[i]);
      rd_reg(ca_t[i], cv_t[i]);
      rd_reg(`UIB_A_IDF, 8'h01);
      irq_is(1'b0);
    end
    // all four classes at once: served in priority order
    wr_reg(`UIB_A_IER, 8'h0f);
    pulse(10'h223);
    rd_reg(`UIB_A_IDF, 8'h06);
    rd_reg(`UIB_A_LSR, 8'h02);
    rd_reg(`UIB_A_IDF, 8'h04);
    rd_reg(`UIB_A_BUF, 8'h00);
    rd_reg(`UIB_A_IDF, 8'h02);
    rd_reg(`UIB_A_IDF, 8'h00);
    rd_reg(`UIB_A_HSR, 8'h01);
    rd_reg(`UIB_A_IDF, 8'h01);
    pulse(10'h020);
    rd_reg(`UIB_A_IDF, 8'h00);
    rd_reg(`UIB_A_HSR, 8'h01);
    pulse(10'h002);
    wr_reg(`UIB_A_BUF, r);
    @(negedge mclk);
    chk(tx_data, r);
    rd_reg(`UIB_A_IDF, 8'h01);
    // every pre-divider with a random divisor
    for (int k = 0; k < 4; k++) begin
      d = $urandom_range(6, 1);
      wr_reg(`UIB_A_CFG, cfg_t[k]);
      wr_reg(`UIB_A_DLL, 8'(d));
      wr_reg(`UIB_A_DLH, 8'h00);
      repeat (500) @(posedge mclk);
      c = 0;
      repeat (NCYC) @(negedge mclk) if (baud_en === 1'b1) c++;
      chk_cnt(c, NCYC * int'(`UIB_SRC_MHZ) * num_t[k]
        / (int'(`UIB_MCLK_MHZ) * int'(`UIB_PD_DEN) * d));
    end
    // fifo mode, trigger level four, fast baud so timeout comes soon
    wr_reg(`UIB_A_CFG, 8'h02);
    wr_reg(`UIB_A_DLL, 8'h01);
    wr_reg(`UIB_A_IER, 8'h01);
    wr_reg(`UIB_A_IDF, 8'h41);
    @(negedge mclk);
    chk({7'h00, fifo_mode}, 8'h01);
    rd_reg(`UIB_A_IDF, 8'hc1);
    repeat (3) pulse(10'h001);
    rd_reg(`UIB_A_IDF, 8'hc1);
    pulse(10'h001);
    rd_reg(`UIB_A_IDF, 8'hc4);
    repeat (150) @(posedge mclk);
    rd_reg(`UIB_A_IDF, 8'hcc);
    rd_reg(`UIB_A_BUF, 8'h00);
    rd_reg(`UIB_A_IDF, 8'hc1);
    wr_reg(`UIB_A_IDF, 8'h01);
    rd_reg(`UIB_A_IDF, 8'hc4);
    wr_reg(`UIB_A_IDF, 8'h81);
    rd_reg(`UIB_A_IDF, 8'hc1);
    repeat (5) pulse(10'h001);
    rd_reg(`UIB_A_IDF, 8'hc4);
    wr_reg(`UIB_A_IDF, 8'hc1);
    rd_reg(`UIB_A_IDF, 8'hc1);
    wr_reg(`UIB_A_IDF, 8'h00);
    @(negedge mclk);
    chk({7'h00, fifo_mode}, 8'h00);
    rd_reg(`UIB_A_IDF, 8'h04);
    wr_reg(`UIB_A_IDF, 8'h07);
    rd_reg(`UIB_A_IDF, 8'hc1);
    chk(8'(n_tfc), 8'h01);
    chk(8'(n_txw), 8'h01);
    repeat (4) @(posedge mclk);
    end_sim();
  end
endmodule : tb
`default_nettype wire
